/* hdl/cpma_pkg.sv */
// Package of the CAN parameter-map agent: group numbers, field positions,
// identifier fields, reset values and timing constants.
// Assumes a single 200 MHz system clock.
package cpma_pkg;

  // Clock and report period.
  localparam int CLK_PERIOD_NS = 5;
  localparam int REPORT_PERIOD_NS = 1000000000;
  localparam int REPORT_PERIOD_CYCLES = REPORT_PERIOD_NS / CLK_PERIOD_NS;

  // Extended identifier layout: [28:24] priority field, [23:8] group number, [7:0] source.
  localparam logic [4:0] ID_PRIORITY = 5'h18;
  localparam logic [7:0] REMOTE_SOURCE = 8'h70;

  // Group numbers.
  localparam logic [15:0] PGN_ENGINE_SPEED = 16'hff90;
  localparam logic [15:0] PGN_MIN_SPEED = 16'hff91;
  localparam logic [15:0] PGN_MAX_SPEED = 16'hff92;
  localparam logic [15:0] PGN_ELECTRICAL = 16'hff93;
  localparam logic [15:0] PGN_HOURS_FUEL = 16'hff94;
  localparam logic [15:0] PGN_CTRL_STATE = 16'hff95;
  localparam logic [15:0] PGN_START_STOP = 16'hff96;
  localparam logic [15:0] PGN_AUTO_MANUAL = 16'hff97;
  localparam logic [15:0] PGN_MANUAL_LOCK = 16'hff98;
  localparam logic [15:0] PGN_PRESTART_ONE = 16'hff99;
  localparam logic [15:0] PGN_PRESTART_TWO = 16'hff9a;
  localparam logic [15:0] PGN_LOADED_SPEED = 16'hff9b;
  localparam logic [15:0] PGN_DISCHARGE = 16'hff9c;
  localparam logic [15:0] PGN_PRESS_START = 16'hff9d;
  localparam logic [15:0] PGN_PRESS_STOP = 16'hff9e;
  localparam logic [15:0] PGN_PRESS_TARGET = 16'hff9f;
  localparam logic [15:0] PGN_PRESS_BAND = 16'hffa0;
  localparam logic [15:0] PGN_SYS_LEVEL = 16'hffa1;
  localparam logic [15:0] PGN_LEVEL_START = 16'hffa2;
  localparam logic [15:0] PGN_LEVEL_STOP = 16'hffa3;
  localparam logic [15:0] PGN_LEVEL_TARGET = 16'hffa4;
  localparam logic [15:0] PGN_NV_SAVE = 16'hffbb;
  localparam logic [4:0] TX_GROUP_COUNT = 5'h15;

  // Payload bit positions of the single-bit fields.
  localparam int BIT_START_STOP = 16;
  localparam int BIT_AUTO_MANUAL = 16;
  localparam int BIT_MANUAL_LOCK = 17;
  localparam int BIT_PRESTART_ONE = 18;
  localparam int BIT_PRESTART_TWO = 19;
  localparam int BIT_NV_SAVE = 16;

  // Reset values of the writable fields.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BAND = 8'h00;
  localparam logic RST_FLAG = 1'b0;

  typedef enum logic [1:0] {
    CPMA_TX_IDLE = 2'b00,
    CPMA_TX_LOAD = 2'b01,
    CPMA_TX_SEND = 2'b10
  } cpma_tx_e;

endpackage

/* hdl/cpma_tick.sv */
// Divider that issues a one-cycle enable pulse every PERIOD clock cycles.
// Assumes PERIOD of at least two.
`timescale 1ns/100ps
module cpma_tick #(
  parameter int PERIOD = 200000000
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  output logic tick_out
);

  localparam int CW = $clog2(PERIOD);

  logic [CW-1:0] count;

  generate
    if (PERIOD < 2)
    begin : g_bad
      $error("cpma_tick: PERIOD must be at least 2");
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count <= '0;
      tick_out <= 1'b0;
    end
    else if (count == CW'(PERIOD - 1))
    begin
      count <= '0;
      tick_out <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule

/* hdl/cpma_sync3.sv */
// Three-stage synchroniser for a level from outside the clock domain.
// The output changes only once the second and third stages agree.
`timescale 1ns/100ps
module cpma_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2[i] == stage3[i])
        begin
          level_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule

/* hdl/cpma_agent.sv */
// CAN parameter-map agent: answers the proprietary parameter groups of an
// engine/pump controller. Frames arrive and leave at payload level; the
// bit-level CAN controller and the nonvolatile store sit outside.
// Assumes rx_valid_in is a one-cycle strobe from logic on clk_in and that
// the transmitter holds tx_ready_in high when it takes a frame.
`timescale 1ns/100ps
module cpma_agent #(
  parameter int REPORT_CYCLES = cpma_pkg::REPORT_PERIOD_CYCLES,
  parameter logic [7:0] DEVICE_SOURCE = 8'h00,
  // Identification patterns; the values are arbitrary.
  parameter logic [7:0] TX_IDENT0 = 8'h5a,
  parameter logic [7:0] TX_IDENT1 = 8'h3c,
  parameter logic [7:0] RX_IDENT0 = 8'h5b,
  parameter logic [7:0] RX_IDENT1 = 8'h3c
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic comm_enable_in,
  input wire logic rx_valid_in,
  input wire logic [28:0] rx_id_in,
  input wire logic [63:0] rx_data_in,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic [28:0] tx_id_out,
  output logic [63:0] tx_data_out,
  input wire logic [15:0] actual_speed_in,
  input wire logic [15:0] target_speed_in,
  input wire logic [15:0] system_voltage_in,
  input wire logic [15:0] oil_pressure_in,
  input wire logic [15:0] engine_temp_in,
  input wire logic [31:0] engine_hours_in,
  input wire logic [15:0] fuel_level_in,
  input wire logic [7:0] ctrl_state_in,
  input wire logic [15:0] discharge_pressure_in,
  input wire logic [15:0] system_level_in,
  input wire logic prestart_one_req_in,
  input wire logic prestart_two_req_in,
  output logic [15:0] min_speed_out,
  output logic [15:0] max_speed_out,
  output logic [15:0] loaded_speed_out,
  output logic [15:0] press_start_out,
  output logic [15:0] press_stop_out,
  output logic [15:0] press_target_out,
  output logic [7:0] press_band_out,
  output logic [15:0] level_start_out,
  output logic [15:0] level_stop_out,
  output logic [15:0] level_target_out,
  output logic auto_mode_out,
  output logic manual_lock_out,
  output logic engine_run_out,
  output logic prestart_one_out,
  output logic prestart_two_out,
  output logic nv_save_out
);

  typedef struct packed {
    logic [15:0] min_speed;
    logic [15:0] max_speed;
    logic [15:0] loaded_speed;
    logic [15:0] press_start;
    logic [15:0] press_stop;
    logic [15:0] press_target;
    logic [7:0] press_band;
    logic [15:0] level_start;
    logic [15:0] level_stop;
    logic [15:0] level_target;
    logic start_stop;
    logic auto_mode;
    logic manual_lock;
    logic pre_one_restrict;
    logic pre_two_restrict;
    logic save_armed;
    logic save_pulse;
    logic [7:0] last_state;
    logic [15:0] state_seconds;
    cpma_pkg::cpma_tx_e tx_state;
    logic [4:0] tx_index;
    logic [28:0] tx_id;
    logic [63:0] tx_data;
  } cpma_state_s;

  cpma_state_s state;
  cpma_state_s next_state;
  logic second_tick;
  logic link_enabled;
  logic auto_active;
  logic rx_accept;
  logic [15:0] rx_pgn;
  logic [15:0] rx_word;
  logic [15:0] tx_pgn;
  logic [63:0] tx_payload;

  generate
    if (REPORT_CYCLES < 2)
    begin : g_bad_period
      $error("cpma_agent: REPORT_CYCLES must be at least 2");
    end
  endgenerate

  cpma_tick #(
    .PERIOD(REPORT_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .tick_out(second_tick)
  );

  // The enable setting is a panel-side level and is treated as asynchronous.
  cpma_sync3 #(
    .WIDTH(1)
  ) u_enable_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in(comm_enable_in),
    .level_out(link_enabled)
  );

  // Manual lock overrides the selected automatic mode.
  assign auto_active = state.auto_mode && !state.manual_lock;

  // Payload bit n is bit n of the vector; byte k holds bits 8k+7..8k, so
  // multi-byte fields go out least significant byte first.
  assign rx_pgn = rx_id_in[23:8];
  assign rx_word = rx_data_in[31:16];
  assign rx_accept = rx_valid_in && link_enabled
    && rx_id_in[28:24] == cpma_pkg::ID_PRIORITY
    && rx_id_in[7:0] == cpma_pkg::REMOTE_SOURCE
    && rx_data_in[7:0] == RX_IDENT0
    && rx_data_in[15:8] == RX_IDENT1;

  assign tx_pgn = cpma_pkg::PGN_ENGINE_SPEED + {11'h000, state.tx_index};

  // Payload of the group picked by the transmit index; all values raw.
  always_comb
  begin
    tx_payload = 64'h0000000000000000;
    tx_payload[7:0] = TX_IDENT0;
    tx_payload[15:8] = TX_IDENT1;
    case (tx_pgn)
      cpma_pkg::PGN_ENGINE_SPEED:
      begin
        tx_payload[31:16] = actual_speed_in;
        tx_payload[47:32] = target_speed_in;
      end
      cpma_pkg::PGN_MIN_SPEED: tx_payload[31:16] = state.min_speed;
      cpma_pkg::PGN_MAX_SPEED: tx_payload[31:16] = state.max_speed;
      cpma_pkg::PGN_ELECTRICAL:
      begin
        tx_payload[31:16] = system_voltage_in;
        tx_payload[47:32] = oil_pressure_in;
        tx_payload[63:48] = engine_temp_in;
      end
      cpma_pkg::PGN_HOURS_FUEL:
      begin
        tx_payload[47:16] = engine_hours_in;
        tx_payload[63:48] = fuel_level_in;
      end
      cpma_pkg::PGN_CTRL_STATE:
      begin
        tx_payload[23:16] = ctrl_state_in;
        tx_payload[39:24] = state.state_seconds;
      end
      cpma_pkg::PGN_START_STOP: tx_payload[cpma_pkg::BIT_START_STOP] = state.start_stop;
      cpma_pkg::PGN_AUTO_MANUAL: tx_payload[cpma_pkg::BIT_AUTO_MANUAL] = state.auto_mode;
      cpma_pkg::PGN_MANUAL_LOCK: tx_payload[cpma_pkg::BIT_MANUAL_LOCK] = state.manual_lock;
      cpma_pkg::PGN_PRESTART_ONE: tx_payload[cpma_pkg::BIT_PRESTART_ONE] = state.pre_one_restrict;
      cpma_pkg::PGN_PRESTART_TWO: tx_payload[cpma_pkg::BIT_PRESTART_TWO] = state.pre_two_restrict;
      cpma_pkg::PGN_LOADED_SPEED: tx_payload[31:16] = state.loaded_speed;
      cpma_pkg::PGN_DISCHARGE: tx_payload[31:16] = discharge_pressure_in;
      cpma_pkg::PGN_PRESS_START: tx_payload[31:16] = state.press_start;
      cpma_pkg::PGN_PRESS_STOP: tx_payload[31:16] = state.press_stop;
      cpma_pkg::PGN_PRESS_TARGET: tx_payload[31:16] = state.press_target;
      cpma_pkg::PGN_PRESS_BAND: tx_payload[23:16] = state.press_band;
      cpma_pkg::PGN_SYS_LEVEL: tx_payload[31:16] = system_level_in;
      cpma_pkg::PGN_LEVEL_START: tx_payload[31:16] = state.level_start;
      cpma_pkg::PGN_LEVEL_STOP: tx_payload[31:16] = state.level_stop;
      cpma_pkg::PGN_LEVEL_TARGET: tx_payload[31:16] = state.level_target;
      default: tx_payload[63:16] = 48'h000000000000;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_state.save_pulse = 1'b0;

    // Elapsed seconds restart whenever the controller changes state.
    next_state.last_state = ctrl_state_in;
    if (ctrl_state_in != state.last_state)
    begin
      next_state.state_seconds = 16'h0000;
    end
    else if (second_tick && state.state_seconds != 16'hffff)
    begin
      next_state.state_seconds = state.state_seconds + 16'h0001;
    end

    // Writes to read-only groups fall to the default branch and change nothing.
    if (rx_accept)
    begin
      case (rx_pgn)
        cpma_pkg::PGN_MIN_SPEED: next_state.min_speed = rx_word;
        cpma_pkg::PGN_MAX_SPEED: next_state.max_speed = rx_word;
        cpma_pkg::PGN_START_STOP: next_state.start_stop = rx_data_in[cpma_pkg::BIT_START_STOP];
        cpma_pkg::PGN_AUTO_MANUAL: next_state.auto_mode = rx_data_in[cpma_pkg::BIT_AUTO_MANUAL];
        cpma_pkg::PGN_MANUAL_LOCK: next_state.manual_lock = rx_data_in[cpma_pkg::BIT_MANUAL_LOCK];
        cpma_pkg::PGN_PRESTART_ONE: next_state.pre_one_restrict = rx_data_in[cpma_pkg::BIT_PRESTART_ONE];
        cpma_pkg::PGN_PRESTART_TWO: next_state.pre_two_restrict = rx_data_in[cpma_pkg::BIT_PRESTART_TWO];
        cpma_pkg::PGN_LOADED_SPEED: next_state.loaded_speed = rx_word;
        cpma_pkg::PGN_PRESS_START: next_state.press_start = rx_word;
        cpma_pkg::PGN_PRESS_STOP: next_state.press_stop = rx_word;
        cpma_pkg::PGN_PRESS_TARGET: next_state.press_target = rx_word;
        cpma_pkg::PGN_PRESS_BAND: next_state.press_band = rx_data_in[23:16];
        cpma_pkg::PGN_LEVEL_START: next_state.level_start = rx_word;
        cpma_pkg::PGN_LEVEL_STOP: next_state.level_stop = rx_word;
        cpma_pkg::PGN_LEVEL_TARGET: next_state.level_target = rx_word;
        cpma_pkg::PGN_NV_SAVE:
        begin
          // A one saves only if it is the first one since reset or a zero has been seen since the last save.
          if (rx_data_in[cpma_pkg::BIT_NV_SAVE])
          begin
            if (state.save_armed)
            begin
              next_state.save_pulse = 1'b1;
              next_state.save_armed = 1'b0;
            end
          end
          else
          begin
            next_state.save_armed = 1'b1;
          end
        end
        default: next_state.save_pulse = 1'b0;
      endcase
    end

    // Broadcast sequence: one pass per second over the 21 groups ff90 to ffa4; the save group ffbb is never sent.
    case (state.tx_state)
      cpma_pkg::CPMA_TX_IDLE:
      begin
        if (second_tick && link_enabled)
        begin
          next_state.tx_index = 5'h00;
          next_state.tx_state = cpma_pkg::CPMA_TX_LOAD;
        end
      end
      cpma_pkg::CPMA_TX_LOAD:
      begin
        if (!link_enabled)
        begin
          next_state.tx_state = cpma_pkg::CPMA_TX_IDLE;
        end
        else
        begin
          next_state.tx_id = {cpma_pkg::ID_PRIORITY, tx_pgn, DEVICE_SOURCE};
          next_state.tx_data = tx_payload;
          next_state.tx_state = cpma_pkg::CPMA_TX_SEND;
        end
      end
      cpma_pkg::CPMA_TX_SEND:
      begin
        if (!link_enabled)
        begin
          next_state.tx_state = cpma_pkg::CPMA_TX_IDLE;
        end
        else if (tx_ready_in)
        begin
          if (state.tx_index == cpma_pkg::TX_GROUP_COUNT - 5'h01)
          begin
            next_state.tx_state = cpma_pkg::CPMA_TX_IDLE;
          end
          else
          begin
            next_state.tx_index = state.tx_index + 5'h01;
            next_state.tx_state = cpma_pkg::CPMA_TX_LOAD;
          end
        end
      end
      default: next_state.tx_state = cpma_pkg::CPMA_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state.min_speed <= cpma_pkg::RST_WORD;
      state.max_speed <= cpma_pkg::RST_WORD;
      state.loaded_speed <= cpma_pkg::RST_WORD;
      state.press_start <= cpma_pkg::RST_WORD;
      state.press_stop <= cpma_pkg::RST_WORD;
      state.press_target <= cpma_pkg::RST_WORD;
      state.press_band <= cpma_pkg::RST_BAND;
      state.level_start <= cpma_pkg::RST_WORD;
      state.level_stop <= cpma_pkg::RST_WORD;
      state.level_target <= cpma_pkg::RST_WORD;
      state.start_stop <= cpma_pkg::RST_FLAG;
      state.auto_mode <= cpma_pkg::RST_FLAG;
      state.manual_lock <= cpma_pkg::RST_FLAG;
      state.pre_one_restrict <= cpma_pkg::RST_FLAG;
      state.pre_two_restrict <= cpma_pkg::RST_FLAG;
      state.save_armed <= 1'b1;
      state.save_pulse <= 1'b0;
      state.last_state <= 8'h00;
      state.state_seconds <= 16'h0000;
      state.tx_state <= cpma_pkg::CPMA_TX_IDLE;
      state.tx_index <= 5'h00;
      state.tx_id <= 29'h00000000;
      state.tx_data <= 64'h0000000000000000;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign tx_valid_out = (state.tx_state == cpma_pkg::CPMA_TX_SEND) && link_enabled;
  assign tx_id_out = state.tx_id;
  assign tx_data_out = state.tx_data;
  assign min_speed_out = state.min_speed;
  assign max_speed_out = state.max_speed;
  assign loaded_speed_out = state.loaded_speed;
  assign press_start_out = state.press_start;
  assign press_stop_out = state.press_stop;
  assign press_target_out = state.press_target;
  assign press_band_out = state.press_band;
  assign level_start_out = state.level_start;
  assign level_stop_out = state.level_stop;
  assign level_target_out = state.level_target;
  assign auto_mode_out = auto_active;
  assign manual_lock_out = state.manual_lock;
  assign engine_run_out = state.start_stop && auto_active;
  assign prestart_one_out = prestart_one_req_in && (!state.pre_one_restrict || auto_active);
  assign prestart_two_out = prestart_two_req_in && (!state.pre_two_restrict || auto_active);
  assign nv_save_out = state.save_pulse;

endmodule

/* tb/cpma_remote.sv */
// Remote CAN node model: sends map writes to the agent and takes its broadcast frames.
// Assumes the agent's clock; all drives happen at the falling edge.
`timescale 1ns/100ps
module cpma_remote #(
  parameter logic [7:0] RX0 = 8'h5b,
  parameter logic [7:0] RX1 = 8'h3c
) (
  input wire logic clk_in,
  output logic rx_valid_out,
  output logic [28:0] rx_id_out,
  output logic [63:0] rx_data_out,
  output logic tx_ready_out,
  input wire logic tx_valid_in,
  input wire logic [28:0] tx_id_in,
  input wire logic [63:0] tx_data_in
);
  logic [92:0] got_q[$];
  int stall = 0;
  initial
  begin
    rx_valid_out = 1'b0;
    rx_id_out = '0;
    rx_data_out = '0;
    tx_ready_out = 1'b0;
  end
  // After the strobe the lines show the inverse, so stale values are never mistaken for a frame.
  task automatic send(input logic [28:0] id, input logic [63:0] data);
    @(negedge clk_in);
    rx_valid_out = 1'b1;
    rx_id_out = id;
    rx_data_out = data;
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    rx_id_out = ~id;
    rx_data_out = ~data;
  endtask
  task automatic send_grp(input logic [15:0] grp, input logic [47:0] pay);
    send({5'h18, grp, 8'h70}, {pay, RX1, RX0});
  endtask
  always @(negedge clk_in)
    tx_ready_out <= (stall == 0) || ($urandom % 3 == 0);
  always @(posedge clk_in)
    if (tx_valid_in && tx_ready_out)
      got_q.push_back({tx_id_in, tx_data_in});
endmodule

/* tb/cpma_agent_assertions.sv */
// Checker of the CAN parameter-map agent: relations between its ports over time.
// Assumes it is bound to the agent and sees only its ports.
`timescale 1ns/100ps
module cpma_agent_assertions #(
  parameter logic [7:0] TX_IDENT0 = 8'h5a,
  parameter logic [7:0] TX_IDENT1 = 8'h3c,
  parameter logic [7:0] RX_IDENT0 = 8'h5b,
  parameter logic [7:0] RX_IDENT1 = 8'h3c
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic rx_valid_in,
  input wire logic [28:0] rx_id_in,
  input wire logic [63:0] rx_data_in,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [28:0] tx_id_out,
  input wire logic [63:0] tx_data_out,
  input wire logic prestart_one_req_in,
  input wire logic prestart_two_req_in,
  input wire logic [15:0] min_speed_out,
  input wire logic auto_mode_out,
  input wire logic manual_lock_out,
  input wire logic engine_run_out,
  input wire logic prestart_one_out,
  input wire logic prestart_two_out,
  input wire logic nv_save_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_run;
    engine_run_out |-> auto_mode_out;
  endproperty
  a_run: assert property (p_run)
    else $error("engine run outside automatic mode");
  property p_lock;
    manual_lock_out |-> !auto_mode_out;
  endproperty
  a_lock: assert property (p_lock)
    else $error("automatic mode while locked to manual");
  property p_pre1;
    (auto_mode_out || !prestart_one_req_in) |-> prestart_one_out == prestart_one_req_in;
  endproperty
  a_pre1: assert property (p_pre1)
    else $error("first prestart output wrong");
  property p_pre2;
    (auto_mode_out || !prestart_two_req_in) |-> prestart_two_out == prestart_two_req_in;
  endproperty
  a_pre2: assert property (p_pre2)
    else $error("second prestart output wrong");
  property p_save_cause;
    nv_save_out |-> $past(rx_valid_in) && $past(rx_id_in) == {5'h18, 16'hffbb, 8'h70} && $past(rx_data_in[16]);
  endproperty
  a_save_cause: assert property (p_save_cause)
    else $error("save pulse without a save frame");
  property p_save_once;
    nv_save_out |=> !nv_save_out;
  endproperty
  a_save_once: assert property (p_save_once)
    else $error("save pulse longer than one cycle");
  property p_min_cause;
    $changed(min_speed_out) |-> $past(rx_valid_in) && $past(rx_id_in) == {5'h18, 16'hff91, 8'h70}
      && $past(rx_data_in[15:0]) == {RX_IDENT1, RX_IDENT0} && min_speed_out == $past(rx_data_in[31:16]);
  endproperty
  a_min_cause: assert property (p_min_cause)
    else $error("minimum speed changed without a valid write");
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=> !tx_valid_out || ($stable(tx_id_out) && $stable(tx_data_out));
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("offered frame changed before it was taken");
  property p_tx_frame;
    tx_valid_out |-> tx_id_out[28:24] == 5'h18 && tx_data_out[15:0] == {TX_IDENT1, TX_IDENT0};
  endproperty
  a_tx_frame: assert property (p_tx_frame)
    else $error("outbound frame header wrong");
  property p_tx_gap;
    tx_valid_out && tx_ready_in |=> !tx_valid_out;
  endproperty
  a_tx_gap: assert property (p_tx_gap)
    else $error("frame offered in the cycle after a handshake");
  c_save: cover property (nv_save_out);
  c_take: cover property (tx_valid_out && tx_ready_in);
  c_stall: cover property (tx_valid_out && !tx_ready_in ##1 tx_valid_out);
endmodule
bind cpma_agent cpma_agent_assertions #(.TX_IDENT0(TX_IDENT0), .TX_IDENT1(TX_IDENT1), .RX_IDENT0(RX_IDENT0),
  .RX_IDENT1(RX_IDENT1)) u_cpma_agent_assertions (.clk_in(clk_in), .rst_b_in(rst_b_in), .rx_valid_in(rx_valid_in),
  .rx_id_in(rx_id_in), .rx_data_in(rx_data_in), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .tx_id_out(tx_id_out), .tx_data_out(tx_data_out), .prestart_one_req_in(prestart_one_req_in),
  .prestart_two_req_in(prestart_two_req_in), .min_speed_out(min_speed_out), .auto_mode_out(auto_mode_out),
  .manual_lock_out(manual_lock_out), .engine_run_out(engine_run_out), .prestart_one_out(prestart_one_out),
  .prestart_two_out(prestart_two_out), .nv_save_out(nv_save_out));

/* tb/tb_can_parameter_map_agent.sv */
// Testbench of the CAN parameter-map agent: writes, refusals, flags, saves, silence and broadcast.
// Assumes the remote node model and the bound checker.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((ex) !== (gt)) begin err_count++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb_can_parameter_map_agent;
  localparam int LIMIT = 6000;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic comm_enable_in = 1'b1;
  logic pre1_req = 1'b0;
  logic pre2_req = 1'b0;
  logic rx_valid, tx_ready, tx_valid, auto_o, lock_o, run_o, pre1_o, pre2_o, save_o, a;
  logic [28:0] rx_id, tx_id;
  logic [63:0] rx_data, tx_data, v;
  logic [15:0] meas[8];
  logic [31:0] hours = 32'h0;
  logic [7:0] state = 8'h0;
  logic [7:0] band, band_mdl;
  logic [15:0] sp_out[9];
  logic [15:0] sp_mdl[9];
  logic [15:0] sp_grp[9] = '{16'hff91, 16'hff92, 16'hff9b, 16'hff9d, 16'hff9e, 16'hff9f, 16'hffa2, 16'hffa3, 16'hffa4};
  logic [11:0] sq = 12'hd9a;
  logic [92:0] f;
  logic [63:0] d[21];
  int err_count = 0, comparisons = 0, cycles = 0, saves = 0, save_mdl = 0, armed = 1;
  // A short report period lets several broadcast passes fit inside the run.
  cpma_agent #(.REPORT_CYCLES(64)) u_cpma_agent (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .comm_enable_in(comm_enable_in),
    .rx_valid_in(rx_valid), .rx_id_in(rx_id), .rx_data_in(rx_data), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .tx_id_out(tx_id), .tx_data_out(tx_data), .actual_speed_in(meas[0]), .target_speed_in(meas[1]),
    .system_voltage_in(meas[2]), .oil_pressure_in(meas[3]), .engine_temp_in(meas[4]), .engine_hours_in(hours),
    .fuel_level_in(meas[5]), .ctrl_state_in(state), .discharge_pressure_in(meas[6]), .system_level_in(meas[7]),
    .prestart_one_req_in(pre1_req), .prestart_two_req_in(pre2_req), .min_speed_out(sp_out[0]),
    .max_speed_out(sp_out[1]), .loaded_speed_out(sp_out[2]), .press_start_out(sp_out[3]),
    .press_stop_out(sp_out[4]), .press_target_out(sp_out[5]), .press_band_out(band), .level_start_out(sp_out[6]),
    .level_stop_out(sp_out[7]), .level_target_out(sp_out[8]), .auto_mode_out(auto_o), .manual_lock_out(lock_o),
    .engine_run_out(run_o), .prestart_one_out(pre1_o), .prestart_two_out(pre2_o), .nv_save_out(save_o));
  cpma_remote u_cpma_remote (.clk_in(clk_in), .rx_valid_out(rx_valid), .rx_id_out(rx_id), .rx_data_out(rx_data),
    .tx_ready_out(tx_ready), .tx_valid_in(tx_valid), .tx_id_in(tx_id), .tx_data_in(tx_data));
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (save_o === 1'b1)
      saves++;
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic check_all();
    wait_n(2);
    for (int i = 0; i < 9; i++)
      `CHK("setpoint", sp_mdl[i], sp_out[i])
    `CHK("deadband", band_mdl, band)
  endtask
  task automatic end_of_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    void'($urandom(32'h7515));
    foreach (meas[i])
      meas[i] = $urandom;
    foreach (sp_mdl[i])
      sp_mdl[i] = 16'h0;
    band_mdl = 8'h0;
    state = 8'($urandom % 17);
    hours = $urandom;
    wait_n(20);
    rst_b_in = 1'b1;
    wait_n(4);
    check_all();
    // Back-to-back writes with noise above each field; the last round writes all ones to the nine setpoints.
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 9; i++)
      begin
        v = {$urandom, $urandom};
        if (r == 2)
          v[31:16] = 16'hffff;
        u_cpma_remote.send_grp(sp_grp[i], v[63:16]);
        sp_mdl[i] = v[31:16];
      end
      v = {$urandom, $urandom};
      u_cpma_remote.send_grp(16'hffa0, v[63:16]);
      band_mdl = v[23:16];
      check_all();
    end
    v = {$urandom, $urandom};
    u_cpma_remote.send({5'h10, 16'hff91, 8'h70}, {v[63:16], 16'h3c5b});
    u_cpma_remote.send({5'h18, 16'hff91, 8'h71}, {v[63:16], 16'h3c5b});
    u_cpma_remote.send({5'h18, 16'hff91, 8'h70}, {v[63:16], 16'h3c5a});
    u_cpma_remote.send_grp(16'hff9c, v[63:16]);
    u_cpma_remote.send_grp(16'hffa6, v[63:16]);
    check_all();
    for (int k = 0; k < 32; k++)
    begin
      u_cpma_remote.send_grp(16'hff97, 48'(k & 1));
      u_cpma_remote.send_grp(16'hff98, 48'(k & 2));
      u_cpma_remote.send_grp(16'hff99, 48'(k & 4));
      u_cpma_remote.send_grp(16'hff9a, 48'(k & 8));
      u_cpma_remote.send_grp(16'hff96, 48'(k >> 4));
      {pre1_req, pre2_req} = 2'($urandom);
      a = k[0] & !k[1];
      wait_n(2);
      `CHK("auto", a, auto_o)
      `CHK("lock", k[1], lock_o)
      `CHK("run", k[4] & a, run_o)
      `CHK("prestart1", pre1_req & (!k[2] | a), pre1_o)
      `CHK("prestart2", pre2_req & (!k[3] | a), pre2_o)
    end
    for (int i = 11; i >= 0; i--)
    begin
      u_cpma_remote.send_grp(16'hffbb, 48'(sq[i]));
      if (sq[i] && armed)
        save_mdl++;
      armed = !sq[i];
    end
    wait_n(3);
    `CHK("saves", save_mdl, saves)
    comm_enable_in = 1'b0;
    wait_n(8);
    u_cpma_remote.got_q.delete();
    u_cpma_remote.send_grp(16'hff91, 48'(~sp_mdl[0]));
    u_cpma_remote.send_grp(16'hffbb, 48'h1);
    wait_n(200);
    check_all();
    `CHK("saves", save_mdl, saves)
    `CHK("frames", 0, u_cpma_remote.got_q.size())
    state = (state == 8'h00) ? 8'h01 : 8'h00;
    u_cpma_remote.stall = 1;
    comm_enable_in = 1'b1;
    for (int t = 0; t < 4000 && u_cpma_remote.got_q.size() < 21; t++)
      wait_n(1);
    `CHK("pass", 1'b1, u_cpma_remote.got_q.size() >= 21)
    for (int i = 0; i < 21 && i < u_cpma_remote.got_q.size(); i++)
    begin
      f = u_cpma_remote.got_q[i];
      d[i] = f[63:0];
      `CHK("header", {5'h18, 16'hff90 + 16'(i), 8'h00, 16'h3c5a}, {f[92:64], f[15:0]})
    end
    `CHK("speeds", {meas[1], meas[0]}, d[0][47:16])
    `CHK("min echo", sp_mdl[0], d[1][31:16])
    `CHK("electrical", {meas[4], meas[3], meas[2]}, d[3][63:16])
    `CHK("hours fuel", {meas[5], hours}, d[4][63:16])
    `CHK("state", state, d[5][23:16])
    `CHK("seconds", 1'b1, d[5][39:24] inside {[16'h0001:16'h0003]})
    `CHK("discharge", meas[6], d[12][31:16])
    `CHK("band echo", band_mdl, d[16][23:16])
    `CHK("level", meas[7], d[17][31:16])
    end_of_test();
  end
endmodule
